/* src/wr_burst_pkg.sv */
// Constants for the write burst timing block.
// Assumes a single core clock and mode settings held stable between writes.
package wr_burst_pkg;
    // Burst length field encodings
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    // Data clocks per burst (two beats per clock)
    localparam logic [2:0] CLKS_BL8 = 3'h4;
    localparam logic [2:0] CLKS_BC4 = 3'h2;
    localparam logic [2:0] CLKS_CRC = 3'h1;
    // Command delay line depth, enough for write latency plus parity latency
    localparam int LINE_DEPTH = 32;
    // Synchroniser stages on the command pins
    localparam int SYNC_STAGES = 2;
    // Command spacings with write CRC on
    localparam logic [3:0] GAP_CRC_1T = 4'h5;
    localparam logic [3:0] GAP_CRC_2T = 4'h7;
    localparam logic [3:0] GAP_BAD_2T = 4'h6;
    // Write latency value that the long preamble may not use
    localparam logic [4:0] CWL_BAD_2T = 5'h09;
    // Reset values
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [4:0] REC_RST = 5'h00;
    localparam logic [3:0] GAP_RST = 4'hF;
endpackage

/* src/wr_burst_timing.sv */
// Write path burst and recovery timing of the memory device.
// Assumes command pins arrive asynchronously and mode settings are static.
// How it works
// - Burst field 1:0 forces four-beat chop.
// - Field 0:1 with A12 low gives chop.
// - Field 0:0, or 0:1 with A12 high, eight.
// - Recovery counts from edge after last beat.
// - DBI without CRC selects DBI recovery values.
// - CRC with short preamble allows spacing five.
// - Long preamble flags write spacing six.
`timescale 1ns/1ns
`default_nettype none
module wr_burst_timing (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Mode settings
    input wire logic [1:0] burst_mode,
    input wire logic [4:0] cwl,
    input wire logic [2:0] parity_lat,
    input wire logic crc_en,
    input wire logic dbi_en,
    input wire logic pre_2t,
    input wire logic [4:0] wr_rec,
    input wire logic [4:0] wr_rec_dbi,
    input wire logic [4:0] wtr,
    input wire logic [4:0] wtr_dbi,
    // Command pins
    input wire logic wr_cmd_pin,
    input wire logic a12_pin,
    input wire logic ap_pin,
    // Status
    output logic data_capture,
    output logic burst_bc4,
    output logic burst_end,
    output logic rec_busy,
    output logic wtr_busy,
    output logic auto_pre_start,
    output logic gap_err,
    output logic cwl_err
);
    // Synchroniser stages for cmd, a12, ap
    logic [2:0] sync1;
    logic [2:0] sync2;
    // Delay line of valid, chop, auto precharge
    logic [wr_burst_pkg::LINE_DEPTH-1:0] line_v, line_c, line_a;
    logic [wr_burst_pkg::LINE_DEPTH-1:0] next_line_v, next_line_c, next_line_a;
    // Burst state
    logic [2:0] cnt, next_cnt;
    logic next_capture, next_bc4, next_end, cur_ap, next_cur_ap;
    // Recovery state
    logic [4:0] rec_cnt, next_rec_cnt, wtr_cnt, next_wtr_cnt;
    logic rec_ap, next_rec_ap, next_auto_pre;
    // Spacing state
    logic [3:0] gap, next_gap;
    logic next_gap_err, next_cwl_err;
    // Decodes
    logic cmd, a12, ap, is_bc4, start, last;
    logic [5:0] tap;
    logic [4:0] rec_val, wtr_val;

    // Chop decision for one write from field and A12
    function automatic logic chop(input logic [1:0] mode, input logic a12_in);
        chop = (mode == wr_burst_pkg::BL_FIXED4) ||
               (mode == wr_burst_pkg::BL_OTF && !a12_in);
    endfunction

    // Two-stage synchroniser on pins
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= {ap_pin, a12_pin, wr_cmd_pin};
            sync2 <= sync1;
        end
    end

    // Combinational decodes
    always_comb begin
        cmd = sync2[0];
        a12 = sync2[1];
        ap = sync2[2];
        is_bc4 = chop(burst_mode, a12);
        // Parity latency extends write latency
        tap = 6'({1'b0, cwl} + {3'h0, parity_lat} - 6'h02);
        start = line_v[tap[4:0]];
        last = (cnt == 3'h1) && !start;
        // DBI values only when CRC is off
        rec_val = (dbi_en && !crc_en) ? wr_rec_dbi : wr_rec;
        wtr_val = (dbi_en && !crc_en) ? wtr_dbi : wtr;
    end

    // Next state of the delay line and burst
    always_comb begin
        next_line_v = {line_v[wr_burst_pkg::LINE_DEPTH-2:0], cmd};
        next_line_c = {line_c[wr_burst_pkg::LINE_DEPTH-2:0], is_bc4};
        next_line_a = {line_a[wr_burst_pkg::LINE_DEPTH-2:0], ap};
        next_cnt = cnt;
        next_bc4 = burst_bc4;
        next_cur_ap = cur_ap;
        if (start) begin
            // Burst length plus one clock when CRC is on
            next_cnt = (line_c[tap[4:0]] ? wr_burst_pkg::CLKS_BC4
                        : wr_burst_pkg::CLKS_BL8)
                       + (crc_en ? wr_burst_pkg::CLKS_CRC : 3'h0);
            next_bc4 = line_c[tap[4:0]];
            next_cur_ap = line_a[tap[4:0]];
        end else if (cnt != 3'h0) begin
            next_cnt = cnt - 3'h1;
        end
        next_capture = (next_cnt != 3'h0);
        next_end = last;
    end

    // Registers for delay line and burst
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            line_v <= '0;
            line_c <= '0;
            line_a <= '0;
            cnt <= wr_burst_pkg::CNT_RST;
            data_capture <= 1'b0;
            burst_bc4 <= 1'b0;
            burst_end <= 1'b0;
            cur_ap <= 1'b0;
        end else begin
            line_v <= next_line_v;
            line_c <= next_line_c;
            line_a <= next_line_a;
            cnt <= next_cnt;
            data_capture <= next_capture;
            burst_bc4 <= next_bc4;
            burst_end <= next_end;
            cur_ap <= next_cur_ap;
        end
    end

    // Next state of recovery and turnaround counters
    always_comb begin
        next_rec_cnt = rec_cnt;
        next_wtr_cnt = wtr_cnt;
        next_rec_ap = rec_ap;
        next_auto_pre = 1'b0;
        if (last) begin
            // Counting begins at the edge after the last data clock
            next_rec_cnt = rec_val;
            next_wtr_cnt = wtr_val;
            next_rec_ap = cur_ap;
        end else begin
            if (rec_cnt != 5'h00) begin
                next_rec_cnt = rec_cnt - 5'h01;
                // Internal precharge once recovery has elapsed
                if (rec_cnt == 5'h01 && rec_ap) begin
                    next_auto_pre = 1'b1;
                    next_rec_ap = 1'b0;
                end
            end
            if (wtr_cnt != 5'h00) begin
                next_wtr_cnt = wtr_cnt - 5'h01;
            end
        end
    end

    // Registers for recovery
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rec_cnt <= wr_burst_pkg::REC_RST;
            wtr_cnt <= wr_burst_pkg::REC_RST;
            rec_ap <= 1'b0;
            auto_pre_start <= 1'b0;
            rec_busy <= 1'b0;
            wtr_busy <= 1'b0;
        end else begin
            rec_cnt <= next_rec_cnt;
            wtr_cnt <= next_wtr_cnt;
            rec_ap <= next_rec_ap;
            auto_pre_start <= next_auto_pre;
            rec_busy <= (next_rec_cnt != 5'h00);
            wtr_busy <= (next_wtr_cnt != 5'h00);
        end
    end

    // Next state of the spacing checks
    always_comb begin
        next_gap = gap;
        next_gap_err = 1'b0;
        if (cmd) begin
            next_gap = 4'h1;
            // Spacing of six is illegal with the long preamble
            next_gap_err = pre_2t && (gap == wr_burst_pkg::GAP_BAD_2T);
        end else if (gap != wr_burst_pkg::GAP_RST) begin
            next_gap = gap + 4'h1;
        end
        // Latency nine is illegal with the long preamble
        next_cwl_err = pre_2t && (cwl == wr_burst_pkg::CWL_BAD_2T);
    end

    // Registers for spacing checks
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            gap <= wr_burst_pkg::GAP_RST;
            gap_err <= 1'b0;
            cwl_err <= 1'b0;
        end else begin
            gap <= next_gap;
            gap_err <= next_gap_err;
            cwl_err <= next_cwl_err;
        end
    end

    // Steps of a burst used by the checks
    sequence s_start;
        start;
    endsequence
    sequence s_last_clock;
        last;
    endsequence

    a_fixed_chop_len: assert property (@(posedge core_clk) disable iff (!nrst)
        s_start ##0 (burst_mode == wr_burst_pkg::BL_FIXED4 && !crc_en)
        |=> data_capture [*2] ##1 !data_capture)
        else $error("fixed chop burst not two clocks");
    a_otf_chop_flag: assert property (@(posedge core_clk) disable iff (!nrst)
        (cmd && burst_mode == wr_burst_pkg::BL_OTF && !a12) |=> line_c[0])
        else $error("on the fly chop not recorded");
    a_bl8_len: assert property (@(posedge core_clk) disable iff (!nrst)
        s_start ##0 (!line_c[tap[4:0]] && !crc_en)
        |=> data_capture [*4] ##1 !data_capture)
        else $error("eight beat burst wrong length");
    a_rec_from_end: assert property (@(posedge core_clk) disable iff (!nrst)
        s_last_clock |=> burst_end && rec_busy == (rec_cnt != 5'h00)
            && rec_cnt == $past(rec_val) && wtr_cnt == $past(wtr_val))
        else $error("recovery not started after last beat");
    a_dbi_recovery: assert property (@(posedge core_clk) disable iff (!nrst)
        s_last_clock ##0 (dbi_en && !crc_en) |=> rec_cnt == $past(wr_rec_dbi))
        else $error("DBI recovery value not used");
    a_crc_len: assert property (@(posedge core_clk) disable iff (!nrst)
        s_start ##0 (crc_en && !line_c[tap[4:0]])
        |=> data_capture [*5])
        else $error("CRC burst not five clocks");
    a_gap_six_flag: assert property (@(posedge core_clk) disable iff (!nrst)
        (cmd && pre_2t && gap == wr_burst_pkg::GAP_BAD_2T) |=> gap_err)
        else $error("spacing six not flagged");
    a_cwl_nine_flag: assert property (@(posedge core_clk) disable iff (!nrst)
        (pre_2t && cwl == wr_burst_pkg::CWL_BAD_2T) |=> cwl_err)
        else $error("latency nine not flagged");
    a_auto_pre_time: assert property (@(posedge core_clk) disable iff (!nrst)
        (rec_cnt == 5'h01 && rec_ap && !last) |=> auto_pre_start ##1 !auto_pre_start)
        else $error("auto precharge not on time");
    a_parity_latency: assert property (@(posedge core_clk) disable iff (!nrst)
        (line_v[0] && !start && cnt == 3'h0 && parity_lat == 3'h4 && cwl == 5'h09)
        |-> ##11 start)
        else $error("parity latency not added");
endmodule // wr_burst_timing
`default_nettype wire

/* testbench/cmd_driver.sv */
// Controller side model that drives the write command pins.
// Assumes the bench raises issue for one clock per wanted write.
`timescale 1ns/1ns
`default_nettype none
module cmd_driver (
    // Clock
    input wire logic core_clk,
    // Requests from the bench
    input wire logic issue,
    input wire logic a12,
    input wire logic ap,
    // Pins toward the device
    output logic wr_cmd_pin,
    output logic a12_pin,
    output logic ap_pin
);
    // Strobe lasts one clock; idle qualifiers toggle so stale values never look valid
    always_ff @(posedge core_clk) begin
        wr_cmd_pin <= issue;
        a12_pin <= issue ? a12 : ~a12_pin;
        ap_pin <= issue ? ap : ~ap_pin;
    end
endmodule // cmd_driver
`default_nettype wire

/* testbench/test_wr_burst_timing.sv */
// Self-checking bench for the write burst timing block.
// Assumes the command model adds one clock before the pins move.
`timescale 1ns/1ns
`default_nettype none
module test_wr_burst_timing;
    logic core_clk, nrst, crc_en, dbi_en, pre_2t, issue, a12, ap;
    logic [1:0] burst_mode;
    logic [4:0] cwl, wr_rec, wr_rec_dbi, wtr, wtr_dbi;
    logic [2:0] parity_lat;
    logic wr_cmd_pin, a12_pin, ap_pin, data_capture, burst_bc4, burst_end;
    logic rec_busy, wtr_busy, auto_pre_start, gap_err, cwl_err;
    logic [16:0] lfsr = 17'h1366A;
    int mismatches = 0;
    int n_compared = 0;
    wr_burst_timing uut (.core_clk(core_clk), .nrst(nrst), .burst_mode(burst_mode), .cwl(cwl),
        .parity_lat(parity_lat), .crc_en(crc_en), .dbi_en(dbi_en), .pre_2t(pre_2t),
        .wr_rec(wr_rec), .wr_rec_dbi(wr_rec_dbi), .wtr(wtr), .wtr_dbi(wtr_dbi),
        .wr_cmd_pin(wr_cmd_pin), .a12_pin(a12_pin), .ap_pin(ap_pin),
        .data_capture(data_capture), .burst_bc4(burst_bc4), .burst_end(burst_end),
        .rec_busy(rec_busy), .wtr_busy(wtr_busy), .auto_pre_start(auto_pre_start),
        .gap_err(gap_err), .cwl_err(cwl_err));
    cmd_driver ctrl (.core_clk(core_clk), .issue(issue), .a12(a12), .ap(ap),
        .wr_cmd_pin(wr_cmd_pin), .a12_pin(a12_pin), .ap_pin(ap_pin));
    // Clock at 125 MHz
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Pseudo-random source
    function automatic int rnd(input int m);
        lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
        return int'(lfsr) % m;
    endfunction
    // Expected chop flag and data clocks of one burst
    function automatic logic exp_bc4(input logic [1:0] m, input logic a);
        return m == wr_burst_pkg::BL_FIXED4 || (m == wr_burst_pkg::BL_OTF && !a);
    endfunction
    function automatic int exp_clks(input logic b, input logic c);
        return (b ? 2 : 4) + (c ? 1 : 0);
    endfunction
    // Compare one value and keep the tally
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // One isolated write, timed from the request edge
    task automatic do_write(input logic a, input logic p);
        int n, len, rc, wt, apc;
        logic b;
        logic [7:0] erc;
        b = exp_bc4(burst_mode, a);
        @(posedge core_clk);
        issue <= 1'b1;
        a12 <= a;
        ap <= p;
        @(posedge core_clk);
        issue <= 1'b0;
        n = 1;
        #1;
        while (data_capture !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("latency", 8'(3 + cwl + parity_lat), 8'(n));
        len = 0;
        while (data_capture === 1'b1 && len < 20) begin
            @(posedge core_clk);
            #1;
            len++;
        end
        chk("data clocks", 8'(exp_clks(b, crc_en)), 8'(len));
        chk("chop flag", {7'h0, b}, {7'h0, burst_bc4});
        chk("burst end", 8'h01, {7'h0, burst_end});
        rc = 0;
        wt = 0;
        apc = 99;
        for (int k = 0; k < 40; k++) begin
            rc += (rec_busy === 1'b1);
            wt += (wtr_busy === 1'b1);
            if (auto_pre_start === 1'b1) apc = k;
            @(posedge core_clk);
            #1;
        end
        // Recovery window the controller must wait out before a precharge
        erc = (dbi_en && !crc_en) ? {3'h0, wr_rec_dbi} : {3'h0, wr_rec};
        chk("recovery", erc, 8'(rc));
        chk("turnaround", (dbi_en && !crc_en) ? {3'h0, wtr_dbi} : {3'h0, wtr}, 8'(wt));
        chk("auto precharge", p ? erc : 8'(99), 8'(apc));
    endtask
    // Two writes sp clocks apart, then watch the spacing flag
    task automatic gap_pair(input int sp, input logic exp);
        logic seen;
        seen = 1'b0;
        for (int k = 0; k < sp + 14; k++) begin
            @(posedge core_clk);
            issue <= (k == 0 || k == sp);
            #1;
            seen |= (gap_err === 1'b1);
        end
        chk("spacing flag", {7'h0, exp}, {7'h0, seen});
        repeat (60) @(posedge core_clk);
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        #160000;
        mismatches++;
        summarize();
    end
    // Main sequence
    initial begin
        {nrst, crc_en, dbi_en, pre_2t, issue, a12, ap} = 7'h00;
        burst_mode = wr_burst_pkg::BL_OTF;
        {cwl, wr_rec, wr_rec_dbi, wtr, wtr_dbi} = {5'h09, 5'h0C, 5'h0D, 5'h04, 5'h05};
        parity_lat = 3'h0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 36; i++) begin
            @(posedge core_clk);
            burst_mode <= 2'(i < 3 ? i : rnd(3));
            crc_en <= 1'(rnd(2));
            dbi_en <= 1'(rnd(2));
            // First writes use latency nine with parity, legal only with the short preamble
            pre_2t <= 1'(i < 3 ? 0 : rnd(2));
            cwl <= 5'(i < 3 ? 9 : 10 + rnd(9));
            parity_lat <= 3'(i < 3 ? 4 : rnd(7));
            {wr_rec, wr_rec_dbi} <= {5'(1 + rnd(24)), 5'(1 + rnd(24))};
            {wtr, wtr_dbi} <= {5'(1 + rnd(12)), 5'(1 + rnd(12))};
            @(posedge core_clk);
            do_write(1'(i == 1 ? 0 : rnd(2)), 1'(i < 2 ? 1 : rnd(2)));
            $display("write %0d done", i);
        end
        @(posedge core_clk);
        {crc_en, pre_2t, parity_lat} <= {2'h3, 3'h0};
        gap_pair(6, 1'b1);
        gap_pair(7, 1'b0);
        pre_2t <= 1'b0;
        gap_pair(6, 1'b0);
        gap_pair(5, 1'b0);
        $display("spacing test done");
        @(posedge core_clk);
        {pre_2t, cwl} <= {1'b1, 5'h09};
        repeat (3) @(posedge core_clk);
        #1;
        chk("latency flag", 8'h01, {7'h0, cwl_err});
        cwl <= 5'h0A;
        repeat (3) @(posedge core_clk);
        #1;
        chk("latency flag", 8'h00, {7'h0, cwl_err});
        $display("latency flag test done");
        summarize();
    end
endmodule // test_wr_burst_timing
`default_nettype wire
